// ===== rtl/vpic_top.v
// Vectored priority interrupt controller with Wishbone registers
// Notes on behaviour
// - Two active-low request outputs drive the core: normal and fast.
// - Source 0 is the fast input and only reaches the fast output.
// - Source 1 is the combined system peripheral request.
// - Sources 2 to 31 except 5 and 22..28 take peripheral or pin requests, each maskable.
// - Each internal source is edge-triggered or level-sensitive.
// - External sources: rising, falling, high level or low level.
// - Sources 1..31 get eight levels; highest pending unmasked drives normal.
// - Higher level source reasserts normal request while lower one serviced.
// - A software 32-bit vector is held for each source.
// - Vector read returns the vector of the source being serviced.
// - In protect mode vector reads cause no state change.
// - Fast forcing moves a normal source onto the fast request.
// - General mask blocks both outputs while detection keeps running.
// - Source numbers equal peripheral identifiers; 29..31 are pins.
//
// The address map and the Wishbone register port were chosen for this implementation.
`timescale 1ns/100ps
`include "vpic_consts.vh"
module vpic_top #(
	parameter NSRC = `VPIC_NUM_SRC
) (
	input  wire        clk_i,
	input  wire        rst_i,
	input  wire        cyc_i,
	input  wire        stb_i,
	input  wire        we_i,
	input  wire [9:2]  adr_i,
	input  wire [3:0]  sel_i,
	input  wire [31:0] dat_i,
	output reg  [31:0] dat_o,
	output reg         ack_o,
	input  wire        fast_interrupt_input_i,
	input  wire        system_peripheral_source_i,
	input  wire [19:0] periph_src_i,
	input  wire        ext_line_zero_i,
	input  wire        ext_line_one_i,
	input  wire        ext_line_two_i,
	output wire        normal_request_out_n_o,
	output wire        fast_request_out_n_o,
	output wire        irq_o
);
	reg  [4:0]  srcmode_r [0:NSRC-1];
	reg  [31:0] vector_r  [0:NSRC-1];
	reg  [31:0] enable_r;
	reg  [31:0] fforce_r;
	reg         prot_r;
	reg         gmask_r;
	reg  [`VPIC_EV_W-1:0] evstat_r;
	reg  [`VPIC_EV_W-1:0] evmask_r;
	// Service stack: one entry per level, bit set while that level serviced
	reg  [7:0]  active_r;
	reg  [4:0]  cur_src_r;

	wire [31:0] raw_src;
	wire [31:0] pend;
	wire [31:0] lvl;
	reg  [31:0] clr_edge;
	reg  [31:0] sw_set;
	wire        wb_req;
	wire        wb_wr;
	wire        wb_rd;
	wire [7:0]  a;

	// Source numbering follows the peripheral identifiers, 5 and 22..28 idle
	assign raw_src[0]     = fast_interrupt_input_i;
	assign raw_src[1]     = system_peripheral_source_i;
	assign raw_src[4:2]   = periph_src_i[2:0];
	assign raw_src[5]     = 1'b0;
	assign raw_src[21:6]  = periph_src_i[19:4];
	assign raw_src[28:22] = 7'h00;
	assign raw_src[29]    = ext_line_zero_i;
	assign raw_src[30]    = ext_line_one_i;
	assign raw_src[31]    = ext_line_two_i;

	genvar g;
	generate
		for (g = 0; g < NSRC; g = g + 1) begin : gen_src
			vpic_src_detect #(
				.EXTERNAL(`VPIC_EXT_MASK >> g & 1)
			) u_det (
				.clk_i   (clk_i),
				.rst_i   (rst_i),
				.src_i   (raw_src[g]),
				.type_i  (srcmode_r[g][4:3]),
				.clr_i   (clr_edge[g]),
				.set_i   (sw_set[g]),
				.pend_o  (pend[g]),
				.level_o (lvl[g])
			);
		end
	endgenerate

	// Unmasked pending sources; unused numbers never take part
	wire [31:0] live = pend & enable_r & `VPIC_USED_MASK;

	// Fast path: source 0 plus every fast-forced source
	wire fast_any = live[0] | (|(live & fforce_r & 32'hfffffffe));

	// Priority search, lower number wins ties within a level
	reg  [4:0] best_src;
	reg  [3:0] best_lvl;
	reg        best_ok;
	integer    i;
	always @* begin
		best_src = 5'h00;
		best_lvl = 4'h0;
		best_ok  = 1'b0;
		for (i = NSRC - 1; i >= 1; i = i - 1) begin
			if (live[i] & ~fforce_r[i] &
			    ({1'b0, srcmode_r[i][2:0]} >= best_lvl) | 
			    (live[i] & ~fforce_r[i] & ~best_ok)) begin
				best_src = i[4:0];
				best_lvl = {1'b0, srcmode_r[i][2:0]};
				best_ok  = 1'b1;
			end
		end
	end

	// Current service level, or none when the stack is empty
	function [3:0] top_level;
		input [7:0] act;
		integer k;
		begin
			top_level = `VPIC_NO_LVL;
			for (k = 0; k < 8; k = k + 1)
				if (act[k])
					top_level = k[3:0];
		end
	endfunction

	wire [3:0] cur_lvl = top_level(active_r);
	wire       nest_ok = best_ok &
	                     ((cur_lvl == `VPIC_NO_LVL) | (best_lvl > cur_lvl));

	// General mask only gates the outputs, detection above runs on
	assign normal_request_out_n_o = ~(nest_ok & ~gmask_r);
	assign fast_request_out_n_o   = ~(fast_any & ~gmask_r);
	assign irq_o = |(evstat_r & evmask_r);

	// Wishbone classic slave, one wait state: registered ack the cycle after the request
	assign wb_req = cyc_i & stb_i & ~ack_o;
	assign wb_wr  = wb_req & we_i;
	assign wb_rd  = wb_req & ~we_i;
	assign a      = adr_i[9:2];

	function [31:0] merge;
		input [31:0] old;
		input [31:0] nw;
		input [3:0]  be;
		begin
			merge = {be[3] ? nw[31:24] : old[31:24],
			         be[2] ? nw[23:16] : old[23:16],
			         be[1] ? nw[15:8]  : old[15:8],
			         be[0] ? nw[7:0]   : old[7:0]};
		end
	endfunction

	// Vector read does the service entry unless protect mode is on
	wire ivr_rd  = wb_rd & (a == `VPIC_A_IVR);
	wire ivr_act = ivr_rd & ~prot_r & nest_ok;
	wire eoi_wr  = wb_wr & (a == `VPIC_A_EOI);
	wire spur    = ivr_rd & ~prot_r & ~nest_ok;
	wire [3:0] eoi_lvl = cur_lvl;

	always @* begin
		clr_edge = 32'h00000000;
		sw_set   = 32'h00000000;
		if (ivr_act)
			clr_edge[best_src] = 1'b1;
		if (wb_rd & (a == `VPIC_A_FVR) & ~prot_r)
			clr_edge[0] = 1'b1;
		if (wb_wr & (a == `VPIC_A_PEND))
			clr_edge = clr_edge | (dat_i & ~lvl);
		if (wb_wr & (a == `VPIC_A_SWSET))
			sw_set = dat_i;
	end

	integer j;
	always @(posedge clk_i) begin
		if (rst_i) begin
			for (j = 0; j < NSRC; j = j + 1) begin
				srcmode_r[j] <= `VPIC_RST_SRCMODE;
				vector_r[j]  <= `VPIC_RST_VECTOR;
			end
			enable_r  <= 32'h00000000;
			fforce_r  <= 32'h00000000;
			prot_r    <= 1'b0;
			gmask_r   <= 1'b0;
			evmask_r  <= 2'h0;
			active_r  <= 8'h00;
			cur_src_r <= 5'h00;
		end else begin
			if (wb_wr) begin
				if (a < `VPIC_A_VECTOR)
					srcmode_r[a[4:0]] <= {dat_i[6:5], dat_i[2:0]};
				else if (a < `VPIC_A_IVR)
					vector_r[a[4:0]] <= merge(vector_r[a[4:0]],
					                          dat_i, sel_i);
				else if (a == `VPIC_A_ENABLE)
					enable_r <= dat_i;
				else if (a == `VPIC_A_FFORCE)
					fforce_r <= dat_i & 32'hfffffffe;
				else if (a == `VPIC_A_CTRL) begin
					prot_r  <= dat_i[`VPIC_CTRL_PROT];
					gmask_r <= dat_i[`VPIC_CTRL_GMASK];
				end else if (a == `VPIC_A_EVMASK)
					evmask_r <= dat_i[`VPIC_EV_W-1:0];
			end
			// Entry pushes the new level; end of service pops the top one
			if (ivr_act) begin
				active_r[best_lvl[2:0]] <= 1'b1;
				cur_src_r <= best_src;
			end else if (eoi_wr & (eoi_lvl != `VPIC_NO_LVL)) begin
				active_r[eoi_lvl[2:0]] <= 1'b0;
			end
		end
	end

	// Event flags: set wins over the write-one clear of the same cycle
	wire [`VPIC_EV_W-1:0] ev_set = {spur, ivr_act & (cur_lvl != `VPIC_NO_LVL)};
	wire [`VPIC_EV_W-1:0] ev_clr = (wb_wr & (a == `VPIC_A_EVSTAT)) ?
	                               dat_i[`VPIC_EV_W-1:0] : 2'h0;
	always @(posedge clk_i) begin
		if (rst_i)
			evstat_r <= 2'h0;
		else
			evstat_r <= (evstat_r & ~ev_clr) | ev_set;
	end

	// Read data and acknowledge, registered so ack follows the request
	always @(posedge clk_i) begin
		if (rst_i) begin
			ack_o <= 1'b0;
			dat_o <= 32'h00000000;
		end else begin
			ack_o <= wb_req;
			dat_o <= 32'h00000000;
			if (wb_rd) begin
				if (a < `VPIC_A_VECTOR)
					dat_o <= {25'h0000000, srcmode_r[a[4:0]][4:3],
					          2'h0, srcmode_r[a[4:0]][2:0]};
				else if (a < `VPIC_A_IVR)
					dat_o <= vector_r[a[4:0]];
				else if (a == `VPIC_A_IVR)
					dat_o <= nest_ok ? vector_r[best_src] :
					         `VPIC_SPUR_VECTOR;
				else if (a == `VPIC_A_FVR)
					dat_o <= vector_r[0];
				else if (a == `VPIC_A_ENABLE)
					dat_o <= enable_r;
				else if (a == `VPIC_A_FFORCE)
					dat_o <= fforce_r;
				else if (a == `VPIC_A_PEND)
					dat_o <= pend & `VPIC_USED_MASK;
				else if (a == `VPIC_A_CTRL)
					dat_o <= {30'h00000000, gmask_r, prot_r};
				else if (a == `VPIC_A_STAT)
					dat_o <= {19'h00000, active_r, cur_src_r};
				else if (a == `VPIC_A_EVSTAT)
					dat_o <= {30'h00000000, evstat_r};
				else if (a == `VPIC_A_EVMASK)
					dat_o <= {30'h00000000, evmask_r};
			end
		end
	end
endmodule

// ===== rtl/vpic_consts.vh
// Register offsets, field layouts and reset values of the interrupt controller
`ifndef VPIC_CONSTS_VH
`define VPIC_CONSTS_VH
`define VPIC_NUM_SRC       32
`define VPIC_PRIO_W        3
`define VPIC_FIQ_SRC       0
`define VPIC_SYS_SRC       1
`define VPIC_EXT0_SRC      29
`define VPIC_EXT1_SRC      30
`define VPIC_EXT2_SRC      31
`define VPIC_EXT_MASK      32'he0000001
`define VPIC_USED_MASK     32'he03fffdf
`define VPIC_A_SRCMODE     8'h00
`define VPIC_A_VECTOR      8'h20
`define VPIC_A_IVR         8'h40
`define VPIC_A_FVR         8'h41
`define VPIC_A_ENABLE      8'h42
`define VPIC_A_FFORCE      8'h43
`define VPIC_A_PEND        8'h44
`define VPIC_A_EOI         8'h45
`define VPIC_A_CTRL        8'h46
`define VPIC_A_STAT        8'h47
`define VPIC_A_EVSTAT      8'h48
`define VPIC_A_EVMASK      8'h49
`define VPIC_A_SWSET       8'h4a
`define VPIC_SM_PRIO_LSB   0
`define VPIC_SM_TYPE_LSB   5
`define VPIC_CTRL_PROT     0
`define VPIC_CTRL_GMASK    1
`define VPIC_EV_NEST       0
`define VPIC_EV_SPUR       1
`define VPIC_EV_W          2
`define VPIC_RST_SRCMODE   5'h00
`define VPIC_RST_VECTOR    32'h00000000
`define VPIC_SPUR_VECTOR   32'h00000000
`define VPIC_NO_SRC        6'h20
`define VPIC_NO_LVL        4'h8
`endif

// ===== rtl/vpic_src_detect.v
// Per-source synchroniser and edge or level detector
`timescale 1ns/100ps
module vpic_src_detect #(
	parameter EXTERNAL = 0
) (
	input  wire       clk_i,
	input  wire       rst_i,
	input  wire       src_i,
	input  wire [1:0] type_i,
	input  wire       clr_i,
	input  wire       set_i,
	output wire       pend_o,
	output wire       level_o
);
	reg  sync1_r;
	reg  sync2_r;
	reg  prev_r;
	reg  edge_r;
	wire lvl;
	wire hit;

	// Internal sources only offer high level or rising edge
	wire act_low = (EXTERNAL != 0) & ~type_i[0];

	always @(posedge clk_i) begin
		if (rst_i) begin
			sync1_r <= 1'b0;
			sync2_r <= 1'b0;
			prev_r  <= 1'b0;
		end else begin
			sync1_r <= src_i;
			sync2_r <= sync1_r;
			prev_r  <= lvl;
		end
	end

	assign lvl = sync2_r ^ act_low;
	assign hit = lvl & ~prev_r;

	// Set beats the clear of the same cycle so no edge is lost
	always @(posedge clk_i) begin
		if (rst_i)
			edge_r <= 1'b0;
		else if ((type_i[1] & hit) | set_i)
			edge_r <= 1'b1;
		else if (clr_i)
			edge_r <= 1'b0;
	end

	assign level_o = lvl;
	assign pend_o  = type_i[1] ? edge_r : (lvl | edge_r);
endmodule

// ===== tb/vpic_src_model.sv
// Source side model: maps source numbers onto the controller's pins
`timescale 1ns/100ps
module vpic_src_model (
	input  wire [31:0] line_i,
	output wire        fast_o,
	output wire        sys_o,
	output wire [19:0] periph_o,
	output wire [2:0]  ext_o
);
	// Line index is the source number; 22..28 reach nothing, 5 drives periph_o[3], which the controller ignores
	assign fast_o   = line_i[0];
	assign sys_o    = line_i[1];
	assign periph_o = {line_i[21:6], line_i[5], line_i[4:2]};
	assign ext_o    = line_i[31:29];
endmodule

// ===== tb/vpic_chk.sv
// Port level checker for the interrupt controller
`timescale 1ns/100ps
module vpic_chk (
	input wire        clk_i,
	input wire        rst_i,
	input wire        cyc_i,
	input wire        stb_i,
	input wire        we_i,
	input wire [9:2]  adr_i,
	input wire [31:0] dat_i,
	input wire [31:0] dat_o,
	input wire        ack_o,
	input wire        normal_request_out_n_o,
	input wire        fast_request_out_n_o,
	input wire        irq_o
);
	reg        gm_r;
	reg [31:0] en_r;
	reg        em_r;
	wire       wr_take = cyc_i && stb_i && we_i && !ack_o;
	// Shadow copies follow writes at the taking edge, like the design
	always @(posedge clk_i) begin
		if (rst_i) begin
			gm_r <= 1'b0;
			en_r <= 32'h0;
			em_r <= 1'b0;
		end else if (wr_take) begin
			if (adr_i == 8'h46) gm_r <= dat_i[1];
			if (adr_i == 8'h42) en_r <= dat_i;
			if (adr_i == 8'h49) em_r <= |dat_i[1:0];
		end
	end
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	ack_pulse_a: assert property (ack_o |=> !ack_o)
		else $error("ack held longer than one cycle");
	ack_answer_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
		else $error("request not answered next cycle");
	ack_cause_a: assert property (ack_o |-> $past(cyc_i && stb_i))
		else $error("ack without request");
	dat_idle_a: assert property (!ack_o |-> dat_o == 32'h0)
		else $error("read data not zero outside ack");
	reset_quiet_a: assert property (disable iff (1'b0)
		$past(rst_i) && !rst_i |-> !ack_o && normal_request_out_n_o
		&& fast_request_out_n_o && !irq_o)
		else $error("outputs active after reset edge");
	gmask_block_a: assert property (gm_r |->
		normal_request_out_n_o && fast_request_out_n_o)
		else $error("request driven under general mask");
	no_enable_a: assert property (en_r == 32'h0 &&
		$past(en_r) == 32'h0 |-> normal_request_out_n_o)
		else $error("normal request with all sources masked");
	irq_mask_a: assert property (!em_r && !$past(em_r) |-> !irq_o)
		else $error("event output with events masked");
endmodule

// ===== tb/tb_top.sv
// Register level testbench of the interrupt controller
`timescale 1ns/100ps
module tb_top;
	reg         clk_i = 1'b0;
	reg         rst_i = 1'b1;
	reg         cyc = 1'b0, stb = 1'b0, we = 1'b0;
	reg  [7:0]  adr = 8'h00;
	reg  [3:0]  sel = 4'h0;
	reg  [31:0] dat = 32'h0, q;
	reg  [31:0] line = 32'he0000001; // Pins idle high
	wire [31:0] dat_o;
	wire        ack_o, nrq_n, frq_n, irq_o, fi, si;
	wire [19:0] ps;
	wire [2:0]  ex;
	integer     n_mismatch = 0, compares = 0, i;
	always #50 clk_i = ~clk_i;
	vpic_src_model vpic_src_model_i (.line_i(line), .fast_o(fi),
		.sys_o(si), .periph_o(ps), .ext_o(ex));
	vpic_top vpic_top_i (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc),
		.stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(dat),
		.dat_o(dat_o), .ack_o(ack_o), .fast_interrupt_input_i(fi),
		.system_peripheral_source_i(si), .periph_src_i(ps),
		.ext_line_zero_i(ex[0]), .ext_line_one_i(ex[1]),
		.ext_line_two_i(ex[2]), .normal_request_out_n_o(nrq_n),
		.fast_request_out_n_o(frq_n), .irq_o(irq_o));
	task report_and_stop;
		begin
			if (n_mismatch == 0 && compares > 0) $display("Result: passed");
			else $display("Result: failed");
			$finish;
		end
	endtask
	task chk(input [31:0] g, input [31:0] e);
		begin
			compares = compares + 1;
			if (g !== e) begin
				n_mismatch = n_mismatch + 1;
				$display("[ERR] t=%0t got %h exp %h", $time, g, e);
			end
		end
	endtask
	task bus(input [7:0] a, input w, input [31:0] d, input [3:0] s);
		integer k;
		begin
			@(posedge clk_i);
			cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= d; sel <= s;
			k = 0;
			@(posedge clk_i);
			while (ack_o !== 1'b1) begin
				k = k + 1;
				if (k > 50) begin
					n_mismatch = n_mismatch + 1;
					report_and_stop;
				end
				@(posedge clk_i);
			end
			// Ack and data are read at the edge that samples ack high
			q = dat_o;
			cyc <= 1'b0;
			stb <= 1'b0;
			we <= 1'b0;
		end
	endtask
	task wr(input [7:0] a, input [31:0] d);
		bus(a, 1'b1, d, 4'hf);
	endtask
	task rd(input [7:0] a, input [31:0] e);
		begin
			bus(a, 1'b0, 32'h0, 4'h0);
			chk(q, e);
		end
	endtask
	// Pins pass two sync flops, so four cycles always suffice
	task pins(input [2:0] e);
		begin
			repeat (4) @(negedge clk_i);
			chk({29'h0, nrq_n, frq_n, irq_o}, {29'h0, e});
		end
	endtask
	task sl(input [31:0] v);
		begin
			@(posedge clk_i);
			line <= v;
		end
	endtask
	initial begin
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b0;
		pins(3'b110);
		for (i = 6; i < 9; i = i + 1) begin
			wr(i[7:0], (i == 8) ? 32'h5 : 32'h2);
			wr(8'h20 + i[7:0], 32'ha0 + i);
		end
		bus(8'h26, 1'b1, 32'h5500ffbb, 4'h2);
		rd(8'h26, 32'h0000ffa6);
		rd(8'h7f, 32'h0);
		wr(8'h49, 32'h1);
		wr(8'h42, 32'h000001c0);
		sl(32'he00000c1);
		pins(3'b010);
		rd(8'h40, 32'h0000ffa6);
		pins(3'b110);
		sl(32'he00001c1);
		pins(3'b010);
		rd(8'h40, 32'ha8);
		rd(8'h48, 32'h1);
		pins(3'b111);
		wr(8'h49, 32'h0);
		pins(3'b110);
		wr(8'h48, 32'h1);
		wr(8'h49, 32'h1);
		pins(3'b110);
		wr(8'h45, 32'h0);
		wr(8'h45, 32'h0);
		sl(32'he0000081);
		pins(3'b010);
		wr(8'h46, 32'h1);
		rd(8'h40, 32'ha7);
		rd(8'h40, 32'ha7);
		pins(3'b010);
		wr(8'h46, 32'h3);
		pins(3'b110);
		wr(8'h46, 32'h0);
		pins(3'b010);
		wr(8'h43, 32'h80);
		pins(3'b100);
		wr(8'h43, 32'h0);
		wr(8'h1d, 32'h43);
		wr(8'h3d, 32'hbd);
		wr(8'h42, 32'h200001c1);
		sl(32'he0000000);
		pins(3'b100);
		sl(32'hc0000001);
		pins(3'b010);
		sl(32'he0000001);
		pins(3'b010);
		rd(8'h40, 32'hbd);
		pins(3'b110);
		wr(8'h45, 32'h0);
		wr(8'h01, 32'h41);
		wr(8'h21, 32'hb1);
		wr(8'h42, 32'h2);
		sl(32'he0000003);
		sl(32'he0000001);
		pins(3'b010);
		rd(8'h40, 32'hb1);
		wr(8'h45, 32'h0);
		pins(3'b110);
		report_and_stop;
	end
endmodule
bind vpic_top vpic_chk vpic_chk_i (.clk_i(clk_i), .rst_i(rst_i),
	.cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
	.dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
	.normal_request_out_n_o(normal_request_out_n_o),
	.fast_request_out_n_o(fast_request_out_n_o), .irq_o(irq_o));
